// ==== hdl/sfh_handshake.sv ====
// Cyclic process-data handshake between a fieldbus controller and the sensor.
// It assumes control words are sampled once per exchange in sys_clk.
// Summary of operation
// - running flag shows run state
// - run ack follows each run request toggle
// - load success shows load outcome
// - ready high when trigger can be accepted
// - trigger echo follows trigger edges
// - status byte 1 reports current job
// - stopped state after reset
// - job executes only in run and stopping states
// - run refused until a job is loaded
// - stop finishes cycle then clears ack, flag
// - load completion sets ack, result, and job only if load ok
// - trigger needs ready and fieldbus source
// - compat mode stop and job change bits
// - compat lights-off bit disables illumination
// - compat status reports load pass, fail
`timescale 1ns/1ns
`default_nettype none
module sfh_handshake (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic compat_mode,
    input wire sfh_pkg::sfh_std_ctrl_type std_control,
    output sfh_pkg::sfh_std_stat_type std_status,
    input wire sfh_pkg::sfh_cmp_ctrl_type compat_control,
    output sfh_pkg::sfh_cmp_stat_type compat_status,
    input wire logic trigger_source_fieldbus,
    input wire logic acq_busy,
    output logic acq_start,
    input wire logic job_cycle_busy,
    output logic run_enable,
    output logic lights_off,
    output logic load_start,
    output logic [7:0] load_job_number,
    output logic load_as_startup,
    input wire logic load_done,
    input wire logic load_ok,
    output logic [7:0] startup_job_number
);
    import sfh_pkg::*;

    sfh_state_type state;
    sfh_state_type next_state;
    logic running_flag;
    logic run_request_ack;
    logic load_ack;
    logic ready;
    logic trigger_echo;
    logic load_success;
    logic job_valid;
    logic [7:0] current_job_number;

    // mode selection of the request sources
    wire eff_run = compat_mode ? ~compat_control.set_offline : std_control.run_request;
    wire eff_load = compat_mode ? compat_control.job_change : std_control.load_request;
    wire [7:0] eff_job = compat_mode ? compat_control.job_number : std_control.requested_job_number;
    wire eff_startup = compat_mode ? 1'b0 : std_control.startup_job_select;
    // unsupported trigger in compat mode ignored
    wire trig_level = ~compat_mode & std_control.trigger;

    wire run_new = eff_run & ~run_request_ack;
    wire stop_new = ~eff_run & run_request_ack;
    wire load_new = eff_load & ~load_ack;
    wire stopped = (state == ST_STOPPED);
    wire loading = (state == ST_LOADING);
    wire stopping = (state == ST_STOPPING);
    wire running = (state == ST_RUNNING);
    // run granted only with a loaded job
    wire grant_run = stopped & run_new & job_valid & ~load_new;
    wire refuse_run = stopped & run_new & ~job_valid & ~load_new;
    wire begin_load = stopped & load_new;
    wire refuse_load = (running | stopping) & load_new;
    wire stop_done = stopping & ~job_cycle_busy;
    wire finish_load = loading & load_done;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_STOPPED: begin
                if (begin_load) begin
                    next_state = ST_LOADING;
                end else if (grant_run) begin
                    next_state = ST_RUNNING;
                end
            end
            ST_RUNNING: begin
                if (!eff_run) begin
                    next_state = ST_STOPPING;
                end
            end
            ST_STOPPING: begin
                if (!job_cycle_busy) begin
                    next_state = ST_STOPPED;
                end
            end
            ST_LOADING: begin
                if (load_done) begin
                    next_state = ST_STOPPED;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state <= ST_STOPPED;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            running_flag <= 1'b0;
        end else if (grant_run) begin
            running_flag <= 1'b1;
        end else if (stop_done) begin
            running_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            run_request_ack <= 1'b0;
        end else if (grant_run || refuse_run) begin
            run_request_ack <= 1'b1;
        end else if (stop_done || (stopped && stop_new)) begin
            run_request_ack <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            load_ack <= 1'b0;
        end else if (finish_load || refuse_load) begin
            load_ack <= 1'b1;
        end else if (!eff_load && !loading) begin
            load_ack <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            load_start <= 1'b0;
            load_job_number <= JOB_RESET;
            load_as_startup <= 1'b0;
        end else begin
            load_start <= begin_load;
            if (begin_load) begin
                load_job_number <= eff_job;
                load_as_startup <= eff_startup;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ready <= 1'b0;
        end else begin
            ready <= (next_state == ST_RUNNING) & ~acq_busy;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            lights_off <= 1'b0;
        end else begin
            lights_off <= compat_mode & compat_control.lights_off;
        end
    end

    assign run_enable = running_flag;

    sfh_trigger_unit u_trigger (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .trigger_level(trig_level),
        .ready(ready),
        .source_is_fieldbus(trigger_source_fieldbus),
        .trigger_echo(trigger_echo),
        .acq_start(acq_start)
    );

    sfh_job_store u_jobs (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .load_done(finish_load),
        .load_ok(load_ok),
        .load_refused(refuse_load),
        .pending_job(load_job_number),
        .pending_startup(load_as_startup),
        .current_job_number(current_job_number),
        .job_valid(job_valid),
        .load_success(load_success),
        .startup_job_number(startup_job_number)
    );

    always_comb begin
        std_status = STAT_RESET;
        std_status.running_flag = running_flag;
        std_status.run_request_ack = run_request_ack;
        std_status.load_ack = load_ack;
        std_status.load_success = load_success;
        std_status.ready = ready;
        std_status.trigger_echo = trigger_echo;
        std_status.current_job_number = current_job_number;
    end

    // compat load pass and fail bits
    always_comb begin
        compat_status = STAT_RESET;
        compat_status.online = running_flag;
        compat_status.load_complete = load_ack & load_success;
        compat_status.load_failed = load_ack & ~load_success;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence s_stop_asked;
        running && !eff_run;
    endsequence

    sequence s_cycle_over;
        stopping && !job_cycle_busy;
    endsequence

    a_run_refused: assert property (refuse_run |=> run_request_ack && !running_flag)
        else $error("run granted without a loaded job");
    a_run_granted: assert property (grant_run |=> running_flag && run_request_ack && running)
        else $error("run request not granted");
    a_stop_holds: assert property (s_stop_asked ##1 (stopping && job_cycle_busy) |=> running_flag)
        else $error("stopped before job cycle finished");
    a_stop_clears: assert property (s_cycle_over |=> !running_flag && !run_request_ack && stopped)
        else $error("stop did not clear flag and ack");
    a_exec_run_only: assert property (run_enable |-> running || stopping)
        else $error("job executing while stopped");
    a_load_done: assert property (finish_load |=> load_ack && current_job_number == ($past(load_ok)
        ? $past(load_job_number) : $past(current_job_number)))
        else $error("load completion not reported");
    a_lights: assert property (compat_mode && compat_control.lights_off |=> lights_off)
        else $error("lights not switched off");
    a_compat_fail: assert property (compat_mode && load_ack && !load_success |-> compat_status.load_failed
        && !compat_status.load_complete)
        else $error("compat failed-load bit wrong");
    a_zero_bits: assert property (!std_status.zero2 && !std_status.zero7 && compat_status.unsupported_hi == 9'h000)
        else $error("unsupported status bit not zero");
    a_ready_running: assert property (ready |-> running_flag)
        else $error("ready while stopped");

    sequence s_load_asked;
        stopped && load_new;
    endsequence

    sequence s_load_launched;
        load_start && loading;
    endsequence

    sequence s_compat_change;
        compat_mode && stopped && compat_control.job_change && !load_ack;
    endsequence

    a_reset_stopped: assert property (!$past(nrst) |-> stopped && !running_flag && !run_request_ack)
        else $error("not stopped after reset");
    a_load_launch: assert property (s_load_asked |=> s_load_launched ##0 load_job_number == $past(eff_job))
        else $error("load from stopped state not started");
    a_compat_load: assert property (s_compat_change |=> load_job_number == $past(compat_control.job_number))
        else $error("compat job change took wrong job number");
    a_load_refused: assert property (refuse_load |=> load_ack && !load_success && !load_start)
        else $error("load accepted outside stopped state");
    a_ack_release: assert property (load_ack && !eff_load && !loading |=> !load_ack)
        else $error("load ack held after request cleared");
    a_ready_busy: assert property (acq_busy |=> !ready)
        else $error("ready while acquisition busy");
    a_compat_pass: assert property (compat_mode && load_ack && load_success |-> compat_status.load_complete)
        else $error("compat completed-load bit wrong");
    a_compat_offline: assert property (compat_mode && running && compat_control.set_offline |=> stopping)
        else $error("compat offline bit did not stop");
    a_stop_keeps: assert property (s_stop_asked |=> stopping && running_flag && run_request_ack)
        else $error("stop cleared flag before cycle end");
    a_ack_withdrawn: assert property (stopped && stop_new |=> !run_request_ack)
        else $error("run ack not withdrawn");
    a_start_pulse: assert property (acq_start |=> !acq_start)
        else $error("acquisition start longer than one cycle");
endmodule : sfh_handshake
`default_nettype wire

// ==== hdl/sfh_job_store.sv ====
// Loaded-job bookkeeping: current job, load result and startup job.
// It assumes load_done is a one-cycle pulse from the job loader.
`timescale 1ns/1ns
`default_nettype none
module sfh_job_store (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic load_done,
    input wire logic load_ok,
    input wire logic load_refused,
    input wire logic [7:0] pending_job,
    input wire logic pending_startup,
    output logic [7:0] current_job_number,
    output logic job_valid,
    output logic load_success,
    output logic [7:0] startup_job_number
);
    import sfh_pkg::*;

    wire good_load = load_done & load_ok;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            current_job_number <= JOB_RESET;
            job_valid <= 1'b0;
            load_success <= 1'b0;
            startup_job_number <= JOB_RESET;
        end else begin
            if (load_done) begin
                load_success <= load_ok;
            end else if (load_refused) begin
                load_success <= 1'b0;
            end
            if (good_load) begin
                current_job_number <= pending_job;
                job_valid <= 1'b1;
            end
            if (good_load && pending_startup) begin
                startup_job_number <= pending_job;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    a_job_update: assert property (good_load |=> current_job_number == $past(pending_job) && job_valid)
        else $error("current job not updated after good load");
    a_load_fail: assert property (load_done && !load_ok |=> !load_success)
        else $error("load success set after failed load");
endmodule : sfh_job_store
`default_nettype wire

// ==== hdl/sfh_pkg.sv ====
// Package for the fieldbus process-data handshake of the vision sensor.
// It assumes control bytes arrive as 16-bit words with byte 1 in bits 15..8.
package sfh_pkg;

    // Standard control word: byte 0 flags in the low byte, job number above.
    typedef struct packed {
        logic [7:0] requested_job_number;
        logic [3:0] unused;
        logic trigger;
        logic startup_job_select;
        logic load_request;
        logic run_request;
    } sfh_std_ctrl_type;

    // Standard status word: byte 0 flags in the low byte, job number above.
    typedef struct packed {
        logic [7:0] current_job_number;
        logic zero7;
        logic trigger_echo;
        logic ready;
        logic load_success;
        logic load_ack;
        logic zero2;
        logic run_request_ack;
        logic running_flag;
    } sfh_std_stat_type;

    // Compatibility-mode device control word.
    typedef struct packed {
        logic [7:0] job_number;
        logic [2:0] unused;
        logic volatile_unsup;
        logic lights_off;
        logic retrain_unsup;
        logic job_change;
        logic set_offline;
    } sfh_cmp_ctrl_type;

    // Compatibility-mode device status word.
    typedef struct packed {
        logic [8:0] unsupported_hi;
        logic load_failed;
        logic load_complete;
        logic general_fault;
        logic [2:0] offline_reason;
        logic online;
    } sfh_cmp_stat_type;

    typedef enum logic [1:0] {
        ST_STOPPED,
        ST_RUNNING,
        ST_STOPPING,
        ST_LOADING
    } sfh_state_type;

    localparam logic [7:0] JOB_RESET = 8'h00;
    localparam logic [15:0] STAT_RESET = 16'h0000;

endpackage : sfh_pkg

// ==== hdl/sfh_trigger_unit.sv ====
// Trigger echo and acquisition start for the standard control word.
// It assumes the trigger level is already steady in the sys_clk domain.
`timescale 1ns/1ns
`default_nettype none
module sfh_trigger_unit (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic trigger_level,
    input wire logic ready,
    input wire logic source_is_fieldbus,
    output logic trigger_echo,
    output logic acq_start
);
    import sfh_pkg::*;

    logic prev;
    wire rise = trigger_level & ~prev;
    wire fall = ~trigger_level & prev;
    wire next_start = rise & ready & source_is_fieldbus;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            prev <= 1'b0;
            trigger_echo <= 1'b0;
            acq_start <= 1'b0;
        end else begin
            prev <= trigger_level;
            acq_start <= next_start;
            if (rise) begin
                trigger_echo <= 1'b1;
            end else if (fall) begin
                trigger_echo <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    a_echo_follows: assert property (rise |=> trigger_echo ##1 (trigger_echo || $past(fall)))
        else $error("trigger echo did not follow rising edge");
    a_start_gated: assert property (acq_start |-> $past(ready) && $past(source_is_fieldbus))
        else $error("acquisition started without ready or fieldbus source");
endmodule : sfh_trigger_unit
`default_nettype wire

// ==== tb/sfh_plc_model.sv ====
// Fieldbus controller model that drives the standard control word.
// It assumes the status word has settled by the falling edge of sys_clk.
`timescale 1ns/1ns
`default_nettype none
module sfh_plc_model (
    input wire logic sys_clk,
    input wire sfh_pkg::sfh_std_stat_type std_status,
    output sfh_pkg::sfh_std_ctrl_type std_control
);
    import sfh_pkg::*;
    initial begin
        std_control = '0;
    end
    // Run level, then wait for the acknowledge.
    task automatic set_run(input logic level, output logic ok);
        int i;
        @(negedge sys_clk);
        std_control.run_request = level;
        for (i = 0; i < 40 && std_status.run_request_ack !== level; i++) @(negedge sys_clk);
        ok = std_status.running_flag;
    endtask : set_run
    // Job load request, acknowledge, then release.
    task automatic load_job(input logic [7:0] job, input logic boot, output logic ok);
        int i;
        @(negedge sys_clk);
        std_control.requested_job_number = job;
        std_control.startup_job_select = boot;
        std_control.load_request = 1'b1;
        for (i = 0; i < 40 && std_status.load_ack !== 1'b1; i++) @(negedge sys_clk);
        ok = std_status.load_success;
        std_control.load_request = 1'b0;
        for (i = 0; i < 40 && std_status.load_ack !== 1'b0; i++) @(negedge sys_clk);
    endtask : load_job
    task automatic set_trig(input logic level);
        @(negedge sys_clk);
        std_control.trigger = level;
    endtask : set_trig
endmodule : sfh_plc_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the process-data handshake.
// It assumes the controller model and a simple job loader stand around it.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import sfh_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic compat_mode = 1'b0;
    logic trigger_source_fieldbus = 1'b1;
    logic acq_busy = 1'b0;
    logic job_cycle_busy = 1'b0;
    logic load_done = 1'b0;
    logic load_ok = 1'b0;
    logic next_ok = 1'b1;
    sfh_std_ctrl_type std_control;
    sfh_std_stat_type std_status;
    sfh_cmp_ctrl_type compat_control = '0;
    sfh_cmp_stat_type compat_status;
    logic acq_start, run_enable, lights_off, load_start, load_as_startup, ok;
    logic [7:0] load_job_number, startup_job_number, job, cur;
    logic [7:0] boot_job = 8'h00;
    int bad_count = 0;
    int num_checks = 0;
    int seed = 21;
    int cyc = 0;
    int acq_n = 0;
    int ld_n = 0;
    int a0, i;
    always #2 sys_clk = ~sys_clk;
    sfh_handshake u_sfh_handshake (
        .sys_clk(sys_clk), .nrst(nrst), .compat_mode(compat_mode),
        .std_control(std_control), .std_status(std_status),
        .compat_control(compat_control), .compat_status(compat_status),
        .trigger_source_fieldbus(trigger_source_fieldbus), .acq_busy(acq_busy),
        .acq_start(acq_start), .job_cycle_busy(job_cycle_busy), .run_enable(run_enable),
        .lights_off(lights_off), .load_start(load_start), .load_job_number(load_job_number),
        .load_as_startup(load_as_startup), .load_done(load_done), .load_ok(load_ok),
        .startup_job_number(startup_job_number)
    );
    sfh_plc_model u_sfh_plc_model (
        .sys_clk(sys_clk), .std_status(std_status), .std_control(std_control)
    );
    // Job loader answers each start three cycles later.
    always @(negedge sys_clk) begin
        load_done <= 1'b0;
        if (load_start === 1'b1) begin
            repeat (3) @(negedge sys_clk);
            load_ok <= next_ok;
            load_done <= 1'b1;
        end
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (acq_start === 1'b1) acq_n <= acq_n + 1;
        if (load_start === 1'b1) ld_n <= ld_n + 1;
        if (cyc == 5000) begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic check1(input string name, input logic seen, input logic exp);
        check(name, {15'h0000, seen}, {15'h0000, exp});
    endtask : check1
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    function automatic logic [15:0] cmp_exp(input logic online, input logic done, input logic pass);
        return {9'h000, done & ~pass, done & pass, 4'h0, online};
    endfunction : cmp_exp
    initial begin
        repeat (5) @(negedge sys_clk);
        nrst = 1'b1;
        @(negedge sys_clk);
        check("std_status", std_status, 16'h0000);
        check("compat_status", compat_status, 16'h0000);
        // Run refused with no job loaded.
        u_sfh_plc_model.set_run(1'b1, ok);
        check1("ack_refused", std_status.run_request_ack, 1'b1);
        check1("run_refused", ok, 1'b0);
        u_sfh_plc_model.set_run(1'b0, ok);
        check1("ack_clear", std_status.run_request_ack, 1'b0);
        // Random loads that pass and fail.
        for (int k = 0; k < 4; k++) begin
            job = 8'($random(seed));
            next_ok = (k != 1);
            u_sfh_plc_model.load_job(job, k != 0, ok);
            if (next_ok) cur = job;
            if (next_ok && k != 0) boot_job = job;
            check1("load_success", ok, next_ok);
            check("current_job", {8'h00, std_status.current_job_number}, {8'h00, cur});
            check("load_job_number", {8'h00, load_job_number}, {8'h00, job});
            check1("load_as_startup", load_as_startup, k != 0);
            check("startup_job", {8'h00, startup_job_number}, {8'h00, boot_job});
        end
        check("load_starts", 16'(ld_n), 16'h0004);
        u_sfh_plc_model.set_run(1'b1, ok);
        check1("running_flag", ok, 1'b1);
        check1("run_enable", run_enable, 1'b1);
        check1("ready", std_status.ready, 1'b1);
        // Triggers with source on, source off, and busy.
        for (int s = 0; s < 3; s++) begin
            trigger_source_fieldbus = (s != 1);
            acq_busy = (s == 2);
            a0 = acq_n;
            repeat (2) @(negedge sys_clk);
            check1("ready_level", std_status.ready, s != 2);
            u_sfh_plc_model.set_trig(1'b1);
            repeat (3) @(negedge sys_clk);
            check1("trigger_echo_hi", std_status.trigger_echo, 1'b1);
            check("acq_starts", 16'(acq_n - a0), 16'(s == 0));
            u_sfh_plc_model.set_trig(1'b0);
            repeat (3) @(negedge sys_clk);
            check1("trigger_echo_lo", std_status.trigger_echo, 1'b0);
        end
        acq_busy = 1'b0;
        trigger_source_fieldbus = 1'b1;
        a0 = ld_n;
        u_sfh_plc_model.load_job(8'h5A, 1'b0, ok);
        check1("load_refused", ok, 1'b0);
        check("refused_starts", 16'(ld_n - a0), 16'h0000);
        // Stop waits for the job cycle to finish.
        job_cycle_busy = 1'b1;
        fork
            u_sfh_plc_model.set_run(1'b0, ok);
            begin
                repeat (8) @(negedge sys_clk);
                check1("still_running", std_status.running_flag, 1'b1);
                job_cycle_busy = 1'b0;
            end
        join
        check("stopped", std_status[7:0], 16'h0000);
        check("job_kept", {8'h00, std_status.current_job_number}, {8'h00, cur});
        // Compatibility words, job changes that pass and fail.
        compat_mode = 1'b1;
        for (int k = 0; k < 2; k++) begin
            job = 8'($random(seed));
            next_ok = ~k[0];
            compat_control = {job, 8'h17};
            for (i = 0; i < 40 && compat_status[6:5] === 2'b00; i++) @(negedge sys_clk);
            check("compat_load", compat_status, cmp_exp(1'b0, 1'b1, next_ok));
            if (next_ok) check("compat_job", {8'h00, std_status.current_job_number}, {8'h00, job});
            compat_control = {job, 8'h15};
            repeat (3) @(negedge sys_clk);
            check("compat_clear", compat_status, 16'h0000);
        end
        // Online and lights off, then offline.
        compat_control = 16'h0008;
        repeat (5) @(negedge sys_clk);
        check("compat_online", compat_status, cmp_exp(1'b1, 1'b0, 1'b0));
        check1("lights_off", lights_off, 1'b1);
        compat_control = 16'h0001;
        repeat (5) @(negedge sys_clk);
        check("compat_offline", compat_status, 16'h0000);
        check1("lights_on", lights_off, 1'b0);
        // Reset after going offline returns to stopped with no job.
        compat_mode = 1'b0;
        nrst = 1'b0;
        repeat (2) @(negedge sys_clk);
        nrst = 1'b1;
        @(negedge sys_clk);
        check("reset_status", std_status, 16'h0000);
        check("reset_startup", {8'h00, startup_job_number}, 16'h0000);
        check1("reset_lights", lights_off, 1'b0);
        u_sfh_plc_model.set_run(1'b1, ok);
        check1("reset_ack", std_status.run_request_ack, 1'b1);
        check1("reset_run_refused", ok, 1'b0);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
